// [src/fdc_cmd_pkg.sv]
// constants and types for the floppy command decoder
package fdc_cmd_pkg;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned STEP_UNIT_MS = 1;
  localparam int unsigned UNLOAD_UNIT_MS = 16;
  localparam int unsigned LOAD_UNIT_MS = 2;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / MS_PER_S;

  // opcode low five bits
  localparam logic [4:0] OP_WRITE_DELETED = 5'h09;
  localparam logic [4:0] OP_SCAN_EQUAL    = 5'h11;
  localparam logic [4:0] OP_SCAN_LOW      = 5'h19;
  localparam logic [4:0] OP_SCAN_HIGH     = 5'h1D;
  localparam logic [4:0] OP_RECALIBRATE   = 5'h07;
  localparam logic [4:0] OP_SENSE_INT     = 5'h08;
  localparam logic [4:0] OP_SPECIFY       = 5'h03;
  localparam logic [4:0] OP_SENSE_DRIVE   = 5'h04;
  localparam logic [4:0] OP_SEEK          = 5'h0F;

  localparam logic [3:0] LEN_RW     = 4'h9;
  localparam logic [3:0] LEN_TWO    = 4'h2;
  localparam logic [3:0] LEN_THREE  = 4'h3;
  localparam logic [3:0] LEN_ONE    = 4'h1;
  localparam logic [3:0] RES_RW     = 4'h7;
  localparam logic [3:0] RES_ONE    = 4'h1;
  localparam logic [3:0] RES_NONE   = 4'h0;
  localparam logic [3:0] IDX_SEL    = 4'h1;
  localparam logic [3:0] IDX_C      = 4'h2;
  localparam logic [3:0] IDX_H      = 4'h3;
  localparam logic [3:0] IDX_R      = 4'h4;
  localparam logic [3:0] IDX_N      = 4'h5;
  localparam logic [3:0] IDX_LAST   = 4'h8;
  localparam logic [7:0] STRIDE_ONE = 8'h01;
  localparam logic [7:0] STRIDE_TWO = 8'h02;
  localparam logic [7:0] ST0_SEEK_END = 8'h20;
  localparam logic [7:0] ST0_INVALID  = 8'h80;
  localparam logic [7:0] ST3_TRACK0   = 8'h10;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_WDEL, CMD_SCAN_EQ, CMD_SCAN_LE, CMD_SCAN_HE,
    CMD_RECAL, CMD_SENSE_INT, CMD_SPECIFY, CMD_SENSE_DRV, CMD_SEEK
  } cmd_t;

  typedef struct packed {
    logic       multi_track_flag;
    logic       density_select_flag;
    logic       bypass_deleted_marks;
    logic       head_select;
    logic [1:0] drive;
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size_code;
    logic [7:0] last_sector_number;
    logic [7:0] gap_three_length;
    logic [7:0] length_or_stride;
  } cmd_params_t;

  typedef struct packed {
    logic [3:0] step_interval;
    logic [3:0] head_unload_delay;
    logic [6:0] head_load_delay;
    logic       polled_transfer_flag;
  } timing_cfg_t;
endpackage : fdc_cmd_pkg

// [src/floppy_command_decoder.sv]
// command, execution and result phase sequencing for the floppy controller
// Behaviour
// RULE1: host selects data register for each transfer
// RULE2: don't-care command bits are ignored
// RULE3: write-deleted takes opcode, params, writes sectors
// RULE4: rw/scan parameters arrive in fixed order
// RULE5: rw/scan return seven result bytes
// RULE6: scans compare host and disk bytes
// RULE7: stride one contiguous, two alternate sectors
// RULE8: recalibrate steps drive to cylinder zero
// RULE9: sense interrupt returns status zero only
// RULE10: sense drive returns drive status byte
// RULE11: seek steps until target cylinder reached
// RULE12: unknown opcode is no-op, back to idle
// RULE13: specify loads step, unload, load, polled
// RULE14: execution starts after last command byte
// RULE15: two select bits give binary drive number
// RULE16: byte counter fixes parameter and result counts
`timescale 1ns/1ps
module floppy_command_decoder
  import fdc_cmd_pkg::*;
#(
  parameter int unsigned DRIVES = 4
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  input  wire logic        register_select_line,
  input  wire logic [7:0]  wr_data,
  input  wire logic        exec_done,
  input  wire logic        scan_byte_valid,
  input  wire logic [7:0]  scan_disk_byte,
  input  wire logic [7:0]  scan_host_byte,
  input  wire logic [7:0]  exec_st1,
  input  wire logic [7:0]  exec_st2,
  input  wire logic        drive_track0,
  input  wire logic [7:0]  drive_flags,
  output logic [7:0]       rd_data,
  output logic             accept_cmd,
  output logic             result_ready,
  output logic             exec_busy,
  output logic             exec_write_deleted,
  output logic             exec_scan,
  output logic [7:0]       sector_step,
  output logic             scan_match,
  output logic             step_pulse,
  output logic             step_dir_in,
  output logic [1:0]       active_drive,
  output timing_cfg_t      timing_cfg,
  output cmd_params_t      params
);
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_EXEC, S_RESULT} phase_t;

  // step period from step_interval, counted in ms units
  localparam int unsigned STEP_MS_CYC = STEP_UNIT_MS * CYC_PER_MS;

  phase_t      phase_r;
  cmd_t        cmd_r;
  logic [3:0]  cnt_r;
  logic [3:0]  need_r;
  logic [3:0]  res_need_r;
  cmd_params_t par_r;
  timing_cfg_t cfg_r;
  logic [7:0]  st0_r;
  logic [7:0]  st0_last_seek_r;
  logic [7:0]  res_st1_r;
  logic [7:0]  res_st2_r;
  logic [7:0]  pcn_r [DRIVES];
  logic [7:0]  target_r;
  logic [23:0] step_tmr_r;
  logic        step_r;
  logic        scan_miss_r;
  logic [7:0]  rd_data_r, rd_mux;
  logic        dr_wr_s1_r, dr_wr_s2_r, dr_rd_s1_r, dr_rd_s2_r;
  logic        dr_wr_d_r, dr_rd_d_r;
  logic        done_s1_r, done_s2_r, sv_s1_r, sv_s2_r, sv_d_r;
  logic        trk0_s1_r, trk0_s2_r, sel_s1_r, sel_s2_r;

  function automatic cmd_t decode_op(input logic [7:0] b);
    logic [4:0] lo;
    lo = b[4:0];                                          // RULE2
    if (lo == OP_WRITE_DELETED && !b[5])      return CMD_WDEL;
    else if (lo == OP_SCAN_EQUAL)             return CMD_SCAN_EQ;
    else if (lo == OP_SCAN_LOW)               return CMD_SCAN_LE;
    else if (lo == OP_SCAN_HIGH)              return CMD_SCAN_HE;
    else if (b == {3'h0, OP_RECALIBRATE})     return CMD_RECAL;
    else if (b == {3'h0, OP_SENSE_INT})       return CMD_SENSE_INT;
    else if (b == {3'h0, OP_SPECIFY})         return CMD_SPECIFY;
    else if (b == {3'h0, OP_SENSE_DRIVE})     return CMD_SENSE_DRV;
    else if (b == {3'h0, OP_SEEK})            return CMD_SEEK;
    else                                      return CMD_NONE;
  endfunction : decode_op

  function automatic logic [3:0] cmd_len(input cmd_t c);
    case (c)
      CMD_WDEL, CMD_SCAN_EQ, CMD_SCAN_LE, CMD_SCAN_HE: return LEN_RW;
      CMD_RECAL, CMD_SENSE_DRV:                        return LEN_TWO;
      CMD_SPECIFY, CMD_SEEK:                           return LEN_THREE;
      default:                                         return LEN_ONE;
    endcase
  endfunction : cmd_len

  function automatic logic [3:0] res_len(input cmd_t c);
    case (c)
      CMD_WDEL, CMD_SCAN_EQ, CMD_SCAN_LE, CMD_SCAN_HE: return RES_RW;
      CMD_SENSE_INT, CMD_SENSE_DRV:                    return RES_ONE;
      default:                                         return RES_NONE;
    endcase
  endfunction : res_len

  // host strobes come from another domain; synchronise then edge detect
  always_ff @(posedge clk) begin
    dr_wr_s1_r <= wr_strobe;
    dr_wr_s2_r <= dr_wr_s1_r;
    dr_wr_d_r  <= dr_wr_s2_r;
    dr_rd_s1_r <= rd_strobe;
    dr_rd_s2_r <= dr_rd_s1_r;
    dr_rd_d_r  <= dr_rd_s2_r;
    done_s1_r  <= exec_done;
    done_s2_r  <= done_s1_r;
    sv_s1_r    <= scan_byte_valid;
    sv_s2_r    <= sv_s1_r;
    sv_d_r     <= sv_s2_r;
    trk0_s1_r  <= drive_track0;
    trk0_s2_r  <= trk0_s1_r;
    sel_s1_r   <= register_select_line;
    sel_s2_r   <= sel_s1_r;
  end

  // data held by the host during the strobe, so it is stable at the edge
  wire         byte_in    = dr_wr_s2_r & ~dr_wr_d_r & sel_s2_r;   // RULE1
  wire         byte_out   = dr_rd_s2_r & ~dr_rd_d_r & sel_s2_r;   // RULE1
  wire         scan_tick  = sv_s2_r & ~sv_d_r;
  wire cmd_t   op_dec     = decode_op(wr_data);
  wire         last_in    = (cnt_r + 4'h1) == need_r;
  wire         is_scan    = (cmd_r == CMD_SCAN_EQ) || (cmd_r == CMD_SCAN_LE) ||
                            (cmd_r == CMD_SCAN_HE);
  wire         is_motion  = (cmd_r == CMD_RECAL) || (cmd_r == CMD_SEEK);
  wire [1:0]   drv        = par_r.drive;                  // RULE15
  wire [7:0]   pcn_cur    = pcn_r[drv];
  wire         at_target  = (cmd_r == CMD_RECAL) ? trk0_s2_r : (pcn_cur == target_r);
  wire [23:0]  step_cyc   = 24'((32'(cfg_r.step_interval) + 32'h1) * STEP_MS_CYC);
  wire         step_due   = step_tmr_r >= step_cyc;
  wire         scan_ok    = (cmd_r == CMD_SCAN_EQ) ? scan_disk_byte == scan_host_byte :
                            (cmd_r == CMD_SCAN_LE) ? scan_disk_byte <= scan_host_byte :
                                                     scan_disk_byte >= scan_host_byte;
  wire         motion_end = is_motion && phase_r == S_EXEC && at_target && !step_r;
  wire         exec_end   = (phase_r == S_EXEC) && (is_motion ? motion_end : done_s2_r);
  wire [7:0]   st0_now    = {6'h00, drv} | {5'h00, par_r.head_select, 2'h0};

  always_comb begin
    case (cnt_r)
      4'h0:    rd_mux = cmd_r == CMD_SENSE_DRV ?                   // RULE10
                        (drive_flags | (trk0_s2_r ? ST3_TRACK0 : 8'h00) | st0_now) :
                        cmd_r == CMD_SENSE_INT ? st0_last_seek_r : st0_r;   // RULE9
      4'h1:    rd_mux = res_st1_r;                                // RULE5
      4'h2:    rd_mux = res_st2_r;
      4'h3:    rd_mux = par_r.cyl;
      4'h4:    rd_mux = par_r.head;
      4'h5:    rd_mux = par_r.sector;
      default: rd_mux = par_r.size_code;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_r <= S_IDLE;
      cmd_r   <= CMD_NONE;
      cnt_r   <= 4'h0;
      need_r  <= 4'h0;
      res_need_r <= 4'h0;
      par_r   <= '0;
      cfg_r   <= '0;
      st0_r   <= 8'h00;
      st0_last_seek_r <= ST0_INVALID;
      res_st1_r <= 8'h00;
      res_st2_r <= 8'h00;
      target_r <= 8'h00;
      step_tmr_r <= 24'h0;
      step_r <= 1'b0;
      scan_miss_r <= 1'b0;
      rd_data_r <= 8'h00;
      for (int i = 0; i < DRIVES; i++) pcn_r[i] <= 8'h00;
    end else begin
      step_r <= 1'b0;
      case (phase_r)
        S_IDLE: if (byte_in) begin
          cmd_r  <= op_dec;
          need_r <= cmd_len(op_dec);                      // RULE16
          res_need_r <= res_len(op_dec);
          cnt_r  <= 4'h1;
          par_r.multi_track_flag     <= wr_data[7];       // RULE3
          par_r.density_select_flag  <= wr_data[6];
          par_r.bypass_deleted_marks <= wr_data[5];
          if (op_dec == CMD_NONE) begin
            st0_last_seek_r <= ST0_INVALID;               // RULE12
            phase_r <= S_IDLE;
          end else if (op_dec == CMD_SENSE_INT) begin
            cnt_r   <= 4'h0;                              // RULE9
            phase_r <= S_RESULT;
          end else phase_r <= S_CMD;
        end
        S_CMD: if (byte_in) begin                         // RULE4
          cnt_r <= cnt_r + 4'h1;
          if (cmd_r == CMD_SPECIFY) begin                 // RULE13
            if (cnt_r == IDX_SEL) begin
              cfg_r.step_interval     <= wr_data[7:4];
              cfg_r.head_unload_delay <= wr_data[3:0];
            end else begin
              cfg_r.head_load_delay      <= wr_data[7:1];
              cfg_r.polled_transfer_flag <= wr_data[0];
            end
          end else if (cnt_r == IDX_SEL) begin
            par_r.head_select <= wr_data[2];
            par_r.drive       <= wr_data[1:0];            // RULE15
          end else if (cmd_r == CMD_SEEK) target_r <= wr_data;  // RULE11
          else if (cnt_r == IDX_C) par_r.cyl <= wr_data;
          else if (cnt_r == IDX_H) par_r.head <= wr_data;
          else if (cnt_r == IDX_R) par_r.sector <= wr_data;
          else if (cnt_r == IDX_N) par_r.size_code <= wr_data;
          else if (cnt_r == IDX_LAST - 4'h2) par_r.last_sector_number <= wr_data;
          else if (cnt_r == IDX_LAST - 4'h1) par_r.gap_three_length <= wr_data;
          else par_r.length_or_stride <= wr_data;         // RULE6
          if (last_in) begin
            step_tmr_r  <= 24'h0;
            scan_miss_r <= 1'b0;
            if (cmd_r == CMD_RECAL) target_r <= 8'h00;    // RULE8
            if (cmd_r == CMD_SPECIFY || cmd_r == CMD_SENSE_DRV) begin
              phase_r <= cmd_r == CMD_SPECIFY ? S_IDLE : S_RESULT;   // RULE10
              cnt_r   <= 4'h0;
            end else phase_r <= S_EXEC;                   // RULE14
          end
        end
        S_EXEC: begin
          if (is_motion && !at_target) begin              // RULE11
            step_tmr_r <= step_due ? 24'h0 : step_tmr_r + 24'h1;
            if (step_due) begin
              step_r <= 1'b1;
              pcn_r[drv] <= step_dir_in ? pcn_cur - 8'h01 : pcn_cur + 8'h01;
            end
          end
          if (is_scan && scan_tick && !scan_ok) scan_miss_r <= 1'b1;   // RULE6
          if (exec_end) begin
            cnt_r     <= 4'h0;
            st0_r     <= st0_now;
            res_st1_r <= exec_st1;
            res_st2_r <= exec_st2;
            if (is_motion) begin                          // RULE8
              if (cmd_r == CMD_RECAL) pcn_r[drv] <= 8'h00;
              st0_last_seek_r <= st0_now | ST0_SEEK_END;
              phase_r <= S_IDLE;
            end else phase_r <= S_RESULT;
          end
        end
        default: if (byte_out) begin                      // RULE16
          cnt_r <= cnt_r + 4'h1;
          if ((cnt_r + 4'h1) >= res_need_r) begin
            phase_r <= S_IDLE;
            cnt_r   <= 4'h0;
          end
        end
      endcase
      rd_data_r <= rd_mux;
    end
  end

  // recalibrate always steps toward cylinder zero; seek steps toward target
  wire dir_in_nxt = (cmd_r == CMD_RECAL) || (target_r < pcn_cur);
  logic dir_r;
  always_ff @(posedge clk) begin
    if (!reset_n) dir_r <= 1'b0;
    else          dir_r <= dir_in_nxt;
  end
  assign step_dir_in = dir_r;

  // stride 2 skips one sector between compares; other values treated as 1
  logic [7:0] stride_r;
  always_ff @(posedge clk) begin
    if (!reset_n) stride_r <= STRIDE_ONE;
    else stride_r <= (par_r.length_or_stride == STRIDE_TWO) ? STRIDE_TWO : STRIDE_ONE;  // RULE7
  end

  logic busy_r, wdel_r, scan_r, acc_r, resr_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      wdel_r <= 1'b0;
      scan_r <= 1'b0;
      acc_r  <= 1'b0;
      resr_r <= 1'b0;
    end else begin
      busy_r <= phase_r == S_EXEC;
      wdel_r <= phase_r == S_EXEC && cmd_r == CMD_WDEL;   // RULE3
      scan_r <= phase_r == S_EXEC && is_scan;
      acc_r  <= phase_r == S_IDLE || phase_r == S_CMD;
      resr_r <= phase_r == S_RESULT;
    end
  end

  assign rd_data            = rd_data_r;
  assign exec_busy          = busy_r;
  assign exec_write_deleted = wdel_r;
  assign exec_scan          = scan_r;
  assign accept_cmd         = acc_r;
  assign result_ready       = resr_r;
  assign sector_step        = stride_r;
  assign scan_match         = ~scan_miss_r;
  assign step_pulse         = step_r;
  assign active_drive       = drv;
  assign timing_cfg         = cfg_r;
  assign params             = par_r;

  a_specify_no_result: assert property (@(posedge clk) disable iff (!reset_n)
    (phase_r == S_CMD && cmd_r == CMD_SPECIFY && byte_in && last_in)
    |=> phase_r == S_IDLE) else $error("specify left idle path"); // RULE13
  a_exec_autostart: assert property (@(posedge clk) disable iff (!reset_n)
    (phase_r == S_CMD && byte_in && last_in && cmd_r == CMD_SEEK)
    |=> phase_r == S_EXEC ##2 exec_busy) else $error("exec did not start"); // RULE14
  a_invalid_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (phase_r == S_IDLE && byte_in && op_dec == CMD_NONE)
    |=> phase_r == S_IDLE) else $error("invalid opcode not ignored"); // RULE12
  a_sense_int_res: assert property (@(posedge clk) disable iff (!reset_n)
    (phase_r == S_IDLE && byte_in && op_dec == CMD_SENSE_INT)
    |=> phase_r == S_RESULT && res_need_r == RES_ONE) else $error("sense int result"); // RULE9
  a_rw_nine_bytes: assert property (@(posedge clk) disable iff (!reset_n)
    (phase_r == S_IDLE && byte_in && op_dec == CMD_WDEL)
    |=> need_r == LEN_RW && res_need_r == RES_RW) else $error("write deleted counts"); // RULE16
  a_recal_home: assert property (@(posedge clk) disable iff (!reset_n)
    (exec_end && cmd_r == CMD_RECAL) |=> pcn_r[drv] == 8'h00 && phase_r == S_IDLE)
    else $error("recalibrate not home"); // RULE8
  a_seek_lands: assert property (@(posedge clk) disable iff (!reset_n)
    (exec_end && cmd_r == CMD_SEEK) |-> pcn_cur == target_r)
    else $error("seek ended off target"); // RULE11
  a_result_count: assert property (@(posedge clk) disable iff (!reset_n)
    (phase_r == S_RESULT) |-> cnt_r < res_need_r) else $error("extra result byte"); // RULE5
  a_stride_two: assert property (@(posedge clk) disable iff (!reset_n)
    (par_r.length_or_stride == STRIDE_TWO) |=> sector_step == STRIDE_TWO)
    else $error("stride not applied"); // RULE7
endmodule : floppy_command_decoder

// [testbench/host_model.sv]
// host processor model that writes command bytes and reads result bytes
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            wr_strobe,
  output logic            rd_strobe,
  output logic            register_select_line,
  output logic [7:0]      wr_data
);
  initial begin
    wr_strobe            = 1'b0;
    rd_strobe            = 1'b0;
    register_select_line = 1'b0;
    wr_data              = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick

  // data held four cycles past the strobe, then inverted so a stale byte cannot pass
  task automatic put_byte(input logic [7:0] b);
    tick(1);
    register_select_line = 1'b1;
    wr_data              = b;
    wr_strobe            = 1'b1;
    tick(5);
    wr_strobe = 1'b0;
    tick(4);
    wr_data              = ~b;
    register_select_line = 1'b0;
    tick(2);
  endtask : put_byte

  // current result byte is taken before the strobe advances the index
  task automatic get_byte(output logic [7:0] b);
    tick(1);
    register_select_line = 1'b1;
    b                    = rd_data;
    rd_strobe            = 1'b1;
    tick(5);
    rd_strobe = 1'b0;
    tick(4);
    register_select_line = 1'b0;
    tick(2);
  endtask : get_byte
endmodule : host_model

// [testbench/tb_top.sv]
// self-checking bench for the floppy command decoder
`timescale 1ns/1ps
module tb_top;
  import fdc_cmd_pkg::*;
  logic        clk, reset_n, wr_strobe, rd_strobe, register_select_line;
  logic [7:0]  wr_data, rd_data, scan_disk_byte, scan_host_byte, exec_st1, exec_st2;
  logic        exec_done, scan_byte_valid, drive_track0;
  logic [7:0]  drive_flags, sector_step;
  logic        accept_cmd, result_ready, exec_busy, exec_write_deleted, exec_scan;
  logic        scan_match, step_pulse, step_dir_in;
  logic [1:0]  active_drive;
  timing_cfg_t timing_cfg;
  cmd_params_t params;
  int          bad_count, n_tests, cyc, steps;
  logic        dir_seen;

  floppy_command_decoder floppy_command_decoder_inst (
    .clk(clk), .reset_n(reset_n), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .register_select_line(register_select_line), .wr_data(wr_data),
    .exec_done(exec_done), .scan_byte_valid(scan_byte_valid),
    .scan_disk_byte(scan_disk_byte), .scan_host_byte(scan_host_byte),
    .exec_st1(exec_st1), .exec_st2(exec_st2), .drive_track0(drive_track0),
    .drive_flags(drive_flags), .rd_data(rd_data), .accept_cmd(accept_cmd),
    .result_ready(result_ready), .exec_busy(exec_busy),
    .exec_write_deleted(exec_write_deleted), .exec_scan(exec_scan),
    .sector_step(sector_step), .scan_match(scan_match), .step_pulse(step_pulse),
    .step_dir_in(step_dir_in), .active_drive(active_drive),
    .timing_cfg(timing_cfg), .params(params));

  host_model host_model_inst (
    .clk(clk), .rd_data(rd_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .register_select_line(register_select_line), .wr_data(wr_data));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (step_pulse === 1'b1) begin
      steps    <= steps + 1;
      dir_seen <= step_dir_in;
    end
    if (cyc == 95000) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: run timed out", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("mismatches %0d of %0d comparisons", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // bounded wait for exec_busy to reach a level
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (exec_busy !== lvl && n < lim) begin
      @(posedge clk);
      n = n + 1;
    end
    #10;
    if (exec_busy !== lvl) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: exec_busy wait ran out", $time);
    end
  endtask : wait_busy

  task automatic sense_int(input logic [7:0] exp);
    logic [7:0] b;
    host_model_inst.put_byte(8'h08);
    check(result_ready, 1'b1, "sense int result phase");
    host_model_inst.get_byte(b);
    check(b, exp, "status zero");
    check({result_ready, accept_cmd}, 2'b01, "sense int single byte");
  endtask : sense_int

  task automatic t_specify();
    host_model_inst.put_byte(8'h03);
    host_model_inst.put_byte(8'h0A);
    host_model_inst.put_byte(8'h0B);
    check(timing_cfg, {4'h0, 4'hA, 7'h05, 1'b1}, "timing config");
    check({accept_cmd, exec_busy, result_ready}, 3'b100, "specify no phases");
  endtask : t_specify

  task automatic t_sense_drive(input logic [7:0] flags, input logic [7:0] sel,
                               input logic [1:0] drv, input logic [7:0] exp);
    logic [7:0] b;
    drive_flags = flags;
    host_model_inst.put_byte(8'h04);
    host_model_inst.put_byte(sel);
    check(active_drive, drv, "binary drive number");
    host_model_inst.get_byte(b);
    check(b, exp, "drive status");
    check(accept_cmd, 1'b1, "one result byte only");
  endtask : t_sense_drive

  task automatic t_invalid();
    host_model_inst.put_byte(8'h00);
    check({accept_cmd, exec_busy, result_ready}, 3'b100, "invalid is no-op");
    sense_int(ST0_INVALID);
  endtask : t_invalid

  task automatic t_seek();
    drive_track0 = 1'b0;
    steps        = 0;
    host_model_inst.put_byte(8'h0F);
    host_model_inst.put_byte(8'h01);
    host_model_inst.put_byte(8'h03);
    check(exec_busy, 1'b1, "seek starts by itself");
    wait_busy(1'b0, 40000);
    check(steps, 3, "steps to target");
    check(dir_seen, 1'b0, "stepping outward");
    check({accept_cmd, result_ready}, 2'b10, "seek no result");
    sense_int(ST0_SEEK_END | 8'h01);
  endtask : t_seek

  task automatic t_recal();
    int n;
    steps = 0;
    host_model_inst.put_byte(8'h07);
    host_model_inst.put_byte(8'h01);
    check(exec_busy, 1'b1, "recalibrate running");
    for (n = 0; n < 12000 && steps == 0; n++) @(posedge clk);
    #10;
    check(dir_seen, 1'b1, "stepping toward zero");
    drive_track0 = 1'b1;
    wait_busy(1'b0, 25000);
    check({accept_cmd, result_ready, exec_busy}, 3'b100, "recal no result");
    sense_int(ST0_SEEK_END | 8'h01);
  endtask : t_recal

  // one pass per read/write-style opcode: write-deleted and the three scans
  task automatic t_rw();
    logic [7:0] ops[4], strd[4], b, exp[7];
    ops  = '{8'hC9, 8'hF1, 8'hF9, 8'hFD};
    strd = '{8'hFF, STRIDE_TWO, STRIDE_ONE, STRIDE_TWO};
    for (int i = 0; i < 4; i++) begin
      host_model_inst.put_byte(ops[i]);
      host_model_inst.put_byte(8'h05);
      host_model_inst.put_byte(8'h0A);
      host_model_inst.put_byte(8'h01);
      host_model_inst.put_byte(8'h03);
      host_model_inst.put_byte(8'h02);
      host_model_inst.put_byte(8'h09);
      host_model_inst.put_byte(8'h1B);
      host_model_inst.put_byte(strd[i]);
      check(params, {ops[i][7:5], 1'b1, 2'h1, 48'h0A01_0302_091B, strd[i]}, "params");
      check({exec_busy, accept_cmd, exec_write_deleted, exec_scan},
            {2'b10, i == 0, i != 0}, "execution phase");
      check(sector_step, (strd[i] == STRIDE_TWO) ? 8'h02 : 8'h01, "stride");
      if (i != 0) begin
        scan_disk_byte  = (i == 2) ? 8'hA5 : 8'h5A;
        scan_host_byte  = scan_disk_byte;
        scan_byte_valid = 1'b1;
        host_model_inst.tick(4);
        scan_byte_valid = 1'b0;
        host_model_inst.tick(4);
        check(scan_match, 1'b1, "equal bytes match");
        scan_host_byte  = (i == 3) ? 8'hF0 : 8'h0F;
        scan_byte_valid = 1'b1;
        host_model_inst.tick(4);
        scan_byte_valid = 1'b0;
        host_model_inst.tick(4);
        check(scan_match, 1'b0, "failed compare seen");
      end
      exec_st1  = i[0] ? 8'hA5 : 8'h5A;
      exec_st2  = i[0] ? 8'hC3 : 8'h3C;
      exec_done = 1'b1;
      wait_busy(1'b0, 20);
      host_model_inst.tick(3);
      exec_done = 1'b0;
      check(result_ready, 1'b1, "result phase");
      exp = '{8'h05, exec_st1, exec_st2, 8'h0A, 8'h01, 8'h03, 8'h02};
      for (int k = 0; k < 7; k++) begin
        host_model_inst.get_byte(b);
        check(b, exp[k], "result byte");
      end
      check({accept_cmd, result_ready}, 2'b10, "seven bytes then idle");
    end
  endtask : t_rw

  initial begin
    reset_n = 1'b0;
    {exec_done, scan_byte_valid, scan_disk_byte, scan_host_byte} = '0;
    {exec_st1, exec_st2, drive_flags} = '0;
    drive_track0 = 1'b1;
    bad_count = 0;
    n_tests   = 0;
    cyc       = 0;
    steps     = 0;
    dir_seen  = 1'b0;
    repeat (4) @(posedge clk);
    #10;
    reset_n = 1'b1;
    host_model_inst.tick(3);
    check({accept_cmd, exec_busy, result_ready, scan_match}, 4'b1001, "reset phase");
    check(sector_step, 8'h01, "reset stride");
    t_specify();
    t_sense_drive(8'hE8, 8'hF6, 2'h2, ST3_TRACK0 | 8'hEE);
    t_sense_drive(8'h17, 8'h08, 2'h0, ST3_TRACK0 | 8'h17);
    t_invalid();
    t_seek();
    t_recal();
    t_rw();
    end_sim();
  end
endmodule : tb_top
